// File: verilog/nv_byte_access.sv
// control logic for byte access to the data nonvolatile memory
`timescale 1ns/1ps
`include "nv_access_defines.svh"

module nv_byte_access #(
	parameter int CLKS_PER_INSTR = `NV_CLKS_PER_INSTR
) (
	// clock and power-on reset
	input  wire logic                      MCLK,
	input  wire logic                      RESET,
	// special function register port from the core
	input  wire logic [7:0]                SFR_ADDR,
	input  wire logic                      SFR_WR,
	input  wire nv_access_pkg::nv_byte_t   SFR_WDATA,
	input  wire logic                      SFR_RD,
	output      nv_access_pkg::nv_byte_t   SFR_RDATA,
	// reset causes: external pin, watchdog, brown-out
	input  wire nv_access_pkg::reset_cause_t RESET_CAUSE,
	// memory array and its write timer
	output      logic [6:0]                MEM_ADDR,
	output      logic                      MEM_RD,
	input  wire nv_access_pkg::nv_byte_t   MEM_RDATA,
	output      nv_access_pkg::nv_byte_t   MEM_WDATA,
	output      logic                      MEM_WR_START,
	output      logic                      MEM_WR_ABORT,
	input  wire logic                      MEM_DONE,
	// write complete event toward the peripheral flag register
	output      logic                      WRITE_DONE
);
	import nv_access_pkg::*;

	localparam int KEY_GAP  = `NV_KEY_GAP_INSTR * CLKS_PER_INSTR;
	localparam int TRIG_GAP = `NV_TRIG_GAP_INSTR * CLKS_PER_INSTR;
	localparam int CNT_W    = $clog2(KEY_GAP + 2);

	// refuse rates the unlock gap counter cannot serve
	if (CLKS_PER_INSTR < 1 || CLKS_PER_INSTR > 64) begin : g_bad_rate
		$error("CLKS_PER_INSTR must be between 1 and 64");
	end

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction : hit

	// ****************************************
	// decode and reset causes
	// ****************************************
	reset_cause_if rc ();
	assign rc.raw = RESET_CAUSE;

	reset_cause_sync u_sync (
		.MCLK  (MCLK),
		.RESET (RESET),
		.rc    (rc)
	);

	logic rst_any;
	assign rst_any = |rc.clean;

	logic wr_data;
	logic wr_addr;
	logic wr_ctrl;
	logic wr_key;
	assign wr_data = SFR_WR && hit(SFR_ADDR, `NV_DATA_ADDR);
	assign wr_addr = SFR_WR && hit(SFR_ADDR, `NV_ADDRESS_ADDR);
	assign wr_ctrl = SFR_WR && hit(SFR_ADDR, `NV_CONTROL_ADDR);
	assign wr_key  = SFR_WR && hit(SFR_ADDR, `NV_UNLOCK_ADDR);

	nv_byte_t      data_reg;
	nv_byte_t      addr_reg;
	logic          write_permit;
	logic          write_busy;
	logic          write_abort_flag;
	unlock_state_t unlock_state;
	logic [CNT_W-1:0] gap_cnt;

	// ****************************************
	// unlock sequence tracker
	// ****************************************
	logic key_ok;
	logic trig_ok;
	logic start_write;
	assign key_ok  = (unlock_state == UNLOCK_KEY1) && wr_key
		&& SFR_WDATA == `NV_KEY_SECOND && gap_cnt == CNT_W'(KEY_GAP - 1);
	assign trig_ok = (unlock_state == UNLOCK_KEY2) && wr_ctrl
		&& SFR_WDATA[`NV_BIT_WR] && gap_cnt == CNT_W'(TRIG_GAP - 1);
	// trigger only takes with permit already set and no write running
	assign start_write = trig_ok && write_permit && !write_busy;

	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			unlock_state <= UNLOCK_IDLE;
			gap_cnt      <= '0;
		end else if (rst_any) begin
			unlock_state <= UNLOCK_IDLE;
			gap_cnt      <= '0;
		end else begin
			gap_cnt <= gap_cnt + CNT_W'(1);
			case (unlock_state)
				UNLOCK_IDLE: begin
					if (wr_key && SFR_WDATA == `NV_KEY_FIRST) begin
						unlock_state <= UNLOCK_KEY1;
						gap_cnt      <= '0;
					end
				end
				UNLOCK_KEY1: begin
					// any other write or a late key abandons the sequence
					if (key_ok) begin
						unlock_state <= UNLOCK_KEY2;
						gap_cnt      <= '0;
					end else if (SFR_WR || gap_cnt >= CNT_W'(KEY_GAP - 1)) begin
						unlock_state <= UNLOCK_IDLE;
					end
				end
				UNLOCK_KEY2: begin
					if (SFR_WR || gap_cnt >= CNT_W'(TRIG_GAP - 1)) begin
						unlock_state <= UNLOCK_IDLE;
					end
				end
				default: begin
					unlock_state <= UNLOCK_IDLE;
				end
			endcase
		end
	end

	// ****************************************
	// control bits
	// ****************************************
	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			write_permit <= 1'b0;
		end else if (rst_any) begin
			write_permit <= 1'b0;
		end else if (wr_ctrl) begin
			// only software and the reset causes move it
			write_permit <= SFR_WDATA[`NV_BIT_PERMIT];
		end
	end

	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			write_busy   <= 1'b0;
			MEM_WR_START <= 1'b0;
			MEM_WR_ABORT <= 1'b0;
			WRITE_DONE   <= 1'b0;
		end else begin
			MEM_WR_START <= 1'b0;
			MEM_WR_ABORT <= 1'b0;
			WRITE_DONE   <= 1'b0;
			if (rst_any) begin
				write_busy   <= 1'b0;
				MEM_WR_ABORT <= write_busy;
			end else if (write_busy) begin
				// permit is not looked at while the write runs
				if (MEM_DONE) begin
					write_busy <= 1'b0;
					WRITE_DONE <= 1'b1;
				end
			end else if (start_write) begin
				write_busy   <= 1'b1;
				MEM_WR_START <= 1'b1;
			end
		end
	end

	// abort flag survives the cause resets; set beats a software clear
	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			write_abort_flag <= 1'b0;
		end else if (rst_any && write_busy) begin
			write_abort_flag <= 1'b1;
		end else if (wr_ctrl) begin
			write_abort_flag <= SFR_WDATA[`NV_BIT_ABORT];
		end
	end

	// ****************************************
	// read path, address and data registers
	// ****************************************
	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			MEM_RD <= 1'b0;
		end else begin
			// writing zero does nothing; a running write masks the read
			MEM_RD <= wr_ctrl && SFR_WDATA[`NV_BIT_RD] && !write_busy
				&& !rst_any;
		end
	end

	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			addr_reg <= `NV_ADDRESS_RESET;
		end else if (wr_addr) begin
			addr_reg <= SFR_WDATA;
		end
	end

	assign MEM_ADDR = addr_reg[6:0];

	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			data_reg <= `NV_DATA_RESET;
		end else if (MEM_RD) begin
			data_reg <= MEM_RDATA;
		end else if (wr_data) begin
			data_reg <= SFR_WDATA;
		end
	end

	assign MEM_WDATA = data_reg;

	// ****************************************
	// register read-back, answered one cycle after the strobe
	// ****************************************
	nv_byte_t read_mux;
	always_comb begin
		read_mux = 8'h00;
		if (hit(SFR_ADDR, `NV_DATA_ADDR)) begin
			read_mux = data_reg;
		end else if (hit(SFR_ADDR, `NV_ADDRESS_ADDR)) begin
			read_mux = addr_reg;
		end else if (hit(SFR_ADDR, `NV_CONTROL_ADDR)) begin
			read_mux = {`NV_UPPER_ZERO, write_abort_flag, write_permit,
				write_busy, MEM_RD};
		end
		// unlock port and unmapped addresses fall through as zero
	end

	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			SFR_RDATA <= 8'h00;
		end else if (SFR_RD) begin
			SFR_RDATA <= read_mux;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (RESET);

	upper_zero_a: assert property (SFR_RD && SFR_ADDR == `NV_CONTROL_ADDR
		|=> SFR_RDATA[7:4] == 4'h0) else $error("control upper bits not zero");
	abort_set_a: assert property (rst_any && write_busy
		|=> write_abort_flag && MEM_WR_ABORT && !write_busy) else $error("abort not flagged");
	permit_gate_a: assert property (MEM_WR_START |-> $past(write_permit))
		else $error("write started without permit");
	read_pulse_a: assert property (MEM_RD |=> !MEM_RD || $past(wr_ctrl))
		else $error("read trigger stuck");
	read_data_a: assert property (MEM_RD |=> data_reg == $past(MEM_RDATA))
		else $error("read data not loaded");
	data_hold_a: assert property (!MEM_RD && !wr_data |=> $stable(data_reg))
		else $error("data register changed");
	unlock_order_a: assert property (MEM_WR_START
		|-> $past(unlock_state == UNLOCK_KEY2 && wr_ctrl)) else $error("write without unlock");
	permit_hold_a: assert property (!wr_ctrl && !rst_any |=> $stable(write_permit))
		else $error("permit changed by hardware");
	done_a: assert property (write_busy && MEM_DONE && !rst_any
		|=> !write_busy && WRITE_DONE) else $error("write end not flagged");
	key_zero_a: assert property (SFR_RD && SFR_ADDR == `NV_UNLOCK_ADDR
		|=> SFR_RDATA == 8'h00) else $error("unlock port not zero");
	no_read_busy_a: assert property (write_busy ##1 write_busy |-> !MEM_RD)
		else $error("read during write");

endmodule : nv_byte_access

// File: verilog/nv_access_defines.svh
// constants for the nonvolatile byte access controller
`ifndef NV_ACCESS_DEFINES_SVH
`define NV_ACCESS_DEFINES_SVH

// ****************************************
// register addresses on the core's special function bus
// ****************************************
`define NV_DATA_ADDR        8'h9A
`define NV_ADDRESS_ADDR     8'h9B
`define NV_CONTROL_ADDR     8'h9C
`define NV_UNLOCK_ADDR      8'h9D

// ****************************************
// control/status field positions
// ****************************************
`define NV_BIT_RD           0
`define NV_BIT_WR           1
`define NV_BIT_PERMIT       2
`define NV_BIT_ABORT        3

// ****************************************
// reset values and unlock keys
// ****************************************
`define NV_DATA_RESET       8'h00
`define NV_ADDRESS_RESET    8'h00
`define NV_UPPER_ZERO       4'h0
`define NV_KEY_FIRST        8'h55
`define NV_KEY_SECOND       8'hAA

// ****************************************
// unlock timing in instruction cycles
// ****************************************
`define NV_KEY_GAP_INSTR    2
`define NV_TRIG_GAP_INSTR   1
`define NV_CLKS_PER_INSTR   4

`endif

// File: verilog/nv_access_pkg.sv
// types shared by the nonvolatile byte access controller
package nv_access_pkg;

	typedef enum logic [2:0] {
		UNLOCK_IDLE = 3'b001,
		UNLOCK_KEY1 = 3'b010,
		UNLOCK_KEY2 = 3'b100
	} unlock_state_t;

	typedef logic [7:0] nv_byte_t;
	typedef logic [2:0] reset_cause_t;

endpackage : nv_access_pkg

// File: verilog/reset_cause_if.sv
// carrier for reset cause requests between the controller and its synchroniser
`timescale 1ns/1ps

interface reset_cause_if;
	import nv_access_pkg::*;
	reset_cause_t raw;
	reset_cause_t clean;

	modport sync (input raw, output clean);
	modport user (output raw, input clean);
endinterface : reset_cause_if

// File: verilog/reset_cause_sync.sv
// three-stage synchroniser with agreement filter for reset cause requests
`timescale 1ns/1ps

module reset_cause_sync (
	// clock and reset
	input  wire logic MCLK,
	input  wire logic RESET,
	// requests
	reset_cause_if.sync rc
);
	import nv_access_pkg::*;

	reset_cause_t stage1;
	reset_cause_t stage2;
	reset_cause_t stage3;

	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			stage1 <= '0;
			stage2 <= '0;
			stage3 <= '0;
		end else begin
			stage1 <= rc.raw;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	// a change counts only once the last two stages agree
	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			rc.clean <= '0;
		end else begin
			for (int i = 0; i < 3; i++) begin
				if (stage2[i] == stage3[i]) begin
					rc.clean[i] <= stage3[i];
				end
			end
		end
	end

endmodule : reset_cause_sync

// File: test/nv_mem_model.sv
// behavioural data array with its write timer
`timescale 1ns/1ps

module nv_mem_model #(
	parameter int WRITE_CLKS = 12
) (
	// clock and reset
	input  wire logic       MCLK,
	input  wire logic       RESET,
	// array side of the controller
	input  wire logic [6:0] MEM_ADDR,
	input  wire logic       MEM_RD,
	output      logic [7:0] MEM_RDATA,
	input  wire logic [7:0] MEM_WDATA,
	input  wire logic       MEM_WR_START,
	input  wire logic       MEM_WR_ABORT,
	output      logic       MEM_DONE
);
	logic [7:0] mem [128];
	logic [6:0] wr_addr;
	logic [7:0] wr_data;
	int         left;

	initial begin
		for (int i = 0; i < 128; i++) begin
			mem[i] = 8'(i) ^ 8'hA5;
		end
	end

	// lines do not hold the last value when no read is asked
	assign MEM_RDATA = MEM_RD ? mem[MEM_ADDR] : ~mem[MEM_ADDR];

	// write duration set by the array's own timer
	always @(posedge MCLK or posedge RESET) begin
		MEM_DONE <= 1'b0;
		if (RESET) begin
			left <= 0;
		end else if (MEM_WR_ABORT) begin
			left <= 0;
		end else if (MEM_WR_START) begin
			wr_addr <= MEM_ADDR;
			wr_data <= MEM_WDATA;
			left    <= WRITE_CLKS;
		end else if (left == 1) begin
			mem[wr_addr] <= wr_data;
			MEM_DONE     <= 1'b1;
			left         <= 0;
		end else if (left > 1) begin
			left <= left - 1;
		end
	end
endmodule : nv_mem_model

// File: test/test_data_nv_byte_access.sv
// self-checking bench of the nonvolatile byte access controller
`timescale 1ns/1ps
`include "nv_access_defines.svh"

module test_data_nv_byte_access;
	import nv_access_pkg::*;
	localparam int KEY_GAP = `NV_KEY_GAP_INSTR;
	logic         MCLK, RESET, SFR_WR, SFR_RD, MEM_RD, MEM_DONE;
	logic         MEM_WR_START, MEM_WR_ABORT, WRITE_DONE;
	logic [7:0]   SFR_ADDR;
	logic [6:0]   MEM_ADDR;
	nv_byte_t     SFR_WDATA, SFR_RDATA, MEM_RDATA, MEM_WDATA;
	reset_cause_t RESET_CAUSE;
	int           fails, n_tests, cycles, starts, aborts;

	nv_byte_access #(.CLKS_PER_INSTR(1)) i_nv_byte_access (.MCLK(MCLK), .RESET(RESET),
		.SFR_ADDR(SFR_ADDR), .SFR_WR(SFR_WR), .SFR_WDATA(SFR_WDATA), .SFR_RD(SFR_RD),
		.SFR_RDATA(SFR_RDATA), .RESET_CAUSE(RESET_CAUSE), .MEM_ADDR(MEM_ADDR),
		.MEM_RD(MEM_RD), .MEM_RDATA(MEM_RDATA), .MEM_WDATA(MEM_WDATA),
		.MEM_WR_START(MEM_WR_START), .MEM_WR_ABORT(MEM_WR_ABORT), .MEM_DONE(MEM_DONE),
		.WRITE_DONE(WRITE_DONE));

	nv_mem_model i_nv_mem_model (.MCLK(MCLK), .RESET(RESET), .MEM_ADDR(MEM_ADDR),
		.MEM_RD(MEM_RD), .MEM_RDATA(MEM_RDATA), .MEM_WDATA(MEM_WDATA),
		.MEM_WR_START(MEM_WR_START), .MEM_WR_ABORT(MEM_WR_ABORT), .MEM_DONE(MEM_DONE));

	initial begin
		MCLK = 1'b0;
		forever #20 MCLK = ~MCLK;
	end

	// a hung wait ends the run as a mismatch
	always @(posedge MCLK) begin
		cycles++;
		if (MEM_WR_START === 1'b1) starts++;
		if (MEM_WR_ABORT === 1'b1) aborts++;
		if (cycles == 20000) begin
			fails++;
			stop_test();
		end
	end

	task stop_test();
		if (fails == 0 && n_tests > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : stop_test

	task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			$display("Error %s expected %h seen %h", what, exp, got);
			fails++;
		end
	endtask : chk

	// ****************************************
	// bus cycles: one access per clock, driven at the falling edge
	// ****************************************
	task bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
		SFR_WR    = w;
		SFR_RD    = r;
		SFR_ADDR  = a;
		SFR_WDATA = d;
		@(negedge MCLK);
	endtask : bus

	task rd(input logic [7:0] a, input logic [7:0] exp, input string what);
		bus(1'b0, 1'b1, a, 8'h00);
		chk(what, exp, SFR_RDATA);
	endtask : rd

	task seq(input int gap, input logic [7:0] trig);
		bus(1'b1, 1'b0, `NV_UNLOCK_ADDR, `NV_KEY_FIRST);
		repeat (gap - 1) bus(1'b0, 1'b0, 8'h00, 8'h00);
		bus(1'b1, 1'b0, `NV_UNLOCK_ADDR, `NV_KEY_SECOND);
		bus(1'b1, 1'b0, `NV_CONTROL_ADDR, trig);
		bus(1'b0, 1'b0, 8'h00, 8'h00);
	endtask : seq

	task t_reset();
		rd(`NV_CONTROL_ADDR, 8'h00, "control");
		bus(1'b1, 1'b0, `NV_UNLOCK_ADDR, 8'hFF);
		rd(`NV_UNLOCK_ADDR, 8'h00, "unlock");
		rd(`NV_DATA_ADDR, `NV_DATA_RESET, "data");
	endtask : t_reset

	task t_read();
		bus(1'b1, 1'b0, `NV_ADDRESS_ADDR, 8'hFB);
		bus(1'b1, 1'b0, `NV_CONTROL_ADDR, 8'h01);
		bus(1'b0, 1'b0, 8'h00, 8'h00);
		rd(`NV_DATA_ADDR, 8'h7B ^ 8'hA5, "read data");
		rd(`NV_CONTROL_ADDR, 8'hF0 & 8'h00, "rd clear");
		rd(`NV_DATA_ADDR, 8'h7B ^ 8'hA5, "data hold");
		bus(1'b1, 1'b0, `NV_DATA_ADDR, 8'h5A);
		rd(`NV_DATA_ADDR, 8'h5A, "data write");
	endtask : t_read

	task t_write();
		int s0;
		bus(1'b1, 1'b0, `NV_ADDRESS_ADDR, 8'h05);
		bus(1'b1, 1'b0, `NV_DATA_ADDR, 8'h3C);
		bus(1'b1, 1'b0, `NV_CONTROL_ADDR, 8'h04);
		s0 = starts;
		seq(KEY_GAP, 8'h06);
		// drop permit and ask for a read while the write runs
		bus(1'b1, 1'b0, `NV_CONTROL_ADDR, 8'h01);
		rd(`NV_CONTROL_ADDR, 8'h02, "busy");
		rd(`NV_DATA_ADDR, 8'h3C, "read masked");
		chk("starts", 8'(s0 + 1), 8'(starts));
		for (int n = 0; n < 100 && WRITE_DONE !== 1'b1; n++) @(negedge MCLK);
		chk("done", 8'h01, {7'h00, WRITE_DONE});
		rd(`NV_CONTROL_ADDR, 8'h00, "wr clear");
		bus(1'b1, 1'b0, `NV_CONTROL_ADDR, 8'h01);
		bus(1'b0, 1'b0, 8'h00, 8'h00);
		rd(`NV_DATA_ADDR, 8'h3C, "written");
	endtask : t_write

	task t_refuse();
		int s0;
		s0 = starts;
		seq(KEY_GAP, 8'h02);
		rd(`NV_CONTROL_ADDR, 8'h00, "no permit");
		bus(1'b1, 1'b0, `NV_CONTROL_ADDR, 8'h04);
		seq(KEY_GAP + 1, 8'h06);
		seq(KEY_GAP - 1, 8'h06);
		chk("refused", 8'(s0), 8'(starts));
		rd(`NV_CONTROL_ADDR, 8'h04, "permit kept");
	endtask : t_refuse

	task t_abort();
		for (int k = 0; k < 3; k++) begin
			bus(1'b1, 1'b0, `NV_CONTROL_ADDR, 8'h04);
			seq(KEY_GAP, 8'h06);
			RESET_CAUSE = 3'(1 << k);
			repeat (8) @(negedge MCLK);
			RESET_CAUSE = 3'b000;
			repeat (6) bus(1'b0, 1'b0, 8'h00, 8'h00);
			rd(`NV_CONTROL_ADDR, 8'h08, "abort");
			chk("aborts", 8'(k + 1), 8'(aborts));
			bus(1'b1, 1'b0, `NV_CONTROL_ADDR, 8'h00);
			rd(`NV_CONTROL_ADDR, 8'h00, "abort clear");
		end
	endtask : t_abort

	initial begin
		{SFR_WR, SFR_RD, SFR_ADDR, SFR_WDATA, RESET_CAUSE} = '0;
		RESET = 1'b1;
		repeat (20) @(negedge MCLK);
		RESET = 1'b0;
		t_reset();
		t_read();
		t_write();
		t_refuse();
		t_abort();
		stop_test();
	end
endmodule : test_data_nv_byte_access
